// File: core/irc_context_ctrl.sv
// control and status register of one isochronous receive context with its engine state
`timescale 1ns/100ps

// What this block does
// (R1) software enables multichannel in one context only
// (R2) software keeps multichannel steady while running
// (R3) split mode streams portions to separate series
// (R4) setting split mode clears multichannel and fill
// (R5) split mode frozen while active or run
// (R6) reserved bits always read zero
// (R7) run changed by software or reset only
// (R8) wake set by software, cleared per fetch
// (R9) dead set on fatal error while active, cleared with run
// (R10) active high only while processing descriptors
// (R11) beta flag set for beta format packets
// (R12) report rate code 000, 001, 010
// (R13) all bits zero after reset
module irc_context_ctrl (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        sw_rst,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata,
    // descriptor engine side
    output logic             desc_fetch_req,
    input  wire logic        desc_fetch_done,
    input  wire logic        desc_last,
    input  wire logic        fatal_error,
    // packet receive side
    input  wire logic        pkt_start,
    input  wire logic        pkt_b_format,
    input  wire logic [2:0]  pkt_rate,
    input  wire logic [15:0] lead_len,
    input  wire logic        word_valid,
    input  wire logic        word_last,
    output logic             leading_portion_series,
    output logic             trailing_portion_series,
    output logic             multi_channel_select,
    output logic             split_payload_mode,
    output logic             context_active
);
    import irc_pkg::*;

    // ****************************************************************
    // control and status bits
    // ****************************************************************
    logic             fill_reg;
    logic             header_reg;
    logic             cycmatch_reg;
    logic             multi_reg;
    logic             split_reg;
    logic             run_reg;
    logic             wake_reg;
    logic             dead_reg;
    logic             bfmt_reg;
    logic [2:0]       rate_reg;
    irc_state_t       state_reg;
    irc_state_t       state_next;
    logic             active;
    logic             any_rst;
    logic             wr_set;
    logic             wr_clr;
    logic             run_clr;
    logic             fetch_ev;
    logic [7:0]       pkt_cnt;
    logic [7:0]       desc_cnt;
    logic [31:0]      ctrl_view;

    assign any_rst  = rst || sw_rst;
    assign wr_set   = reg_wr && (reg_addr == IRC_CTRL_SET_OFS);
    assign wr_clr   = reg_wr && (reg_addr == IRC_CTRL_CLR_OFS);
    assign run_clr  = wr_clr && reg_wdata[IRC_BIT_RUN] && run_reg;
    assign fetch_ev = (state_reg == IRC_FETCH) && desc_fetch_done;
    assign active   = (state_reg == IRC_FETCH) || (state_reg == IRC_RECEIVE); // R10

    // ****************************************************************
    // run: only software writes and resets move it
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (any_rst) begin
            run_reg <= 1'b0; // R7 R13
        end else if (wr_set && reg_wdata[IRC_BIT_RUN]) begin
            run_reg <= 1'b1; // R7
        end else if (wr_clr && reg_wdata[IRC_BIT_RUN]) begin
            run_reg <= 1'b0; // R7
        end
    end

    // ****************************************************************
    // mode bits
    // ****************************************************************
    // split mode is frozen while the context runs so a packet never changes layout midway
    always_ff @(posedge clk) begin
        if (any_rst) begin
            split_reg <= 1'b0; // R13
        end else if (!active && !run_reg) begin // R5
            if (wr_set && reg_wdata[IRC_BIT_SPLIT]) begin
                split_reg <= 1'b1;
            end else if (wr_clr && reg_wdata[IRC_BIT_SPLIT]) begin
                split_reg <= 1'b0;
            end
        end
    end

    // setting split mode wins over a set of multichannel or fill in the same write
    always_ff @(posedge clk) begin
        if (any_rst) begin
            multi_reg <= 1'b0; // R13
            fill_reg  <= 1'b0;
        end else if (wr_set && reg_wdata[IRC_BIT_SPLIT] && !active && !run_reg) begin
            multi_reg <= 1'b0; // R4
            fill_reg  <= 1'b0; // R4
        end else if (wr_set) begin
            // software must keep multichannel steady while running
            multi_reg <= multi_reg | reg_wdata[IRC_BIT_MULTI]; // R1 R2
            fill_reg  <= fill_reg | reg_wdata[IRC_BIT_FILL];
        end else if (wr_clr) begin
            multi_reg <= multi_reg & ~reg_wdata[IRC_BIT_MULTI];
            fill_reg  <= fill_reg & ~reg_wdata[IRC_BIT_FILL];
        end
    end

    // header and cycle-match bits are plain storage here
    always_ff @(posedge clk) begin
        if (any_rst) begin
            header_reg   <= 1'b0;
            cycmatch_reg <= 1'b0;
        end else if (wr_set) begin
            header_reg   <= header_reg | reg_wdata[IRC_BIT_HEADER];
            cycmatch_reg <= cycmatch_reg | reg_wdata[IRC_BIT_CYCMATCH];
        end else if (wr_clr) begin
            header_reg   <= header_reg & ~reg_wdata[IRC_BIT_HEADER];
            cycmatch_reg <= cycmatch_reg & ~reg_wdata[IRC_BIT_CYCMATCH];
        end
    end

    // ****************************************************************
    // wake: software sets, each descriptor fetch clears
    // ****************************************************************
    // a set arriving with a fetch wins, so a resume request is never lost
    always_ff @(posedge clk) begin
        if (any_rst) begin
            wake_reg <= 1'b0; // R13
        end else if (wr_set && reg_wdata[IRC_BIT_WAKE]) begin
            wake_reg <= 1'b1; // R8
        end else if (fetch_ev) begin
            wake_reg <= 1'b0; // R8
        end
    end

    // ****************************************************************
    // dead: fatal error while active sets, clearing run clears
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (any_rst) begin
            dead_reg <= 1'b0; // R13
        end else if (fatal_error && active) begin
            dead_reg <= 1'b1; // R9
        end else if (run_clr) begin
            dead_reg <= 1'b0; // R9
        end
    end

    // ****************************************************************
    // received packet status
    // ****************************************************************
    // beta flag and rate follow the most recent packet start taken while active
    always_ff @(posedge clk) begin
        if (any_rst) begin
            bfmt_reg <= 1'b0; // R13
            rate_reg <= IRC_RATE_S100;
        end else if (pkt_start && active) begin
            bfmt_reg <= pkt_b_format; // R11
            rate_reg <= pkt_rate; // R12
        end
    end

    // ****************************************************************
    // descriptor engine
    // ****************************************************************
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            IRC_IDLE: begin
                if (run_reg && !dead_reg) begin
                    state_next = IRC_FETCH;
                end
            end
            IRC_FETCH: begin
                if (desc_fetch_done) begin
                    state_next = IRC_RECEIVE;
                end
            end
            IRC_RECEIVE: begin
                if (word_valid && word_last) begin
                    // last descriptor parks the engine until software wakes it
                    state_next = (desc_last && !wake_reg) ? IRC_HALT : IRC_FETCH;
                end
            end
            IRC_HALT: begin
                if (wake_reg) begin
                    state_next = IRC_FETCH;
                end
            end
            default: state_next = IRC_IDLE;
        endcase
        // stopping or a fatal error always drops the engine back to idle
        if (!run_reg || fatal_error || dead_reg) begin
            state_next = IRC_IDLE; // R9 R10
        end
    end

    always_ff @(posedge clk) begin
        if (any_rst) begin
            state_reg <= IRC_IDLE; // R13
        end else begin
            state_reg <= state_next;
        end
    end

    // ****************************************************************
    // payload steering and counters
    // ****************************************************************
    irc_portion_split u_split (
        .clk         (clk),
        .rst         (any_rst),
        .enable      (split_reg),
        .lead_len    (lead_len),
        .word_valid  (word_valid && (state_reg == IRC_RECEIVE)),
        .word_last   (word_last),
        .to_leading  (leading_portion_series),
        .to_trailing (trailing_portion_series)
    ); // R3

    irc_event_cnt u_pkt_cnt (
        .clk         (clk),
        .rst         (any_rst),
        .clear       (run_clr),
        .event_pulse (pkt_start && active),
        .count       (pkt_cnt)
    );

    irc_event_cnt u_desc_cnt (
        .clk         (clk),
        .rst         (any_rst),
        .clear       (run_clr),
        .event_pulse (fetch_ev),
        .count       (desc_cnt)
    );

    // ****************************************************************
    // read back
    // ****************************************************************
    always_comb begin
        ctrl_view                    = IRC_CTRL_RESET; // R6
        ctrl_view[IRC_BIT_FILL]      = fill_reg;
        ctrl_view[IRC_BIT_HEADER]    = header_reg;
        ctrl_view[IRC_BIT_CYCMATCH]  = cycmatch_reg;
        ctrl_view[IRC_BIT_MULTI]     = multi_reg;
        ctrl_view[IRC_BIT_SPLIT]     = split_reg;
        ctrl_view[IRC_BIT_RUN]       = run_reg;
        ctrl_view[IRC_BIT_WAKE]      = wake_reg;
        ctrl_view[IRC_BIT_DEAD]      = dead_reg;
        ctrl_view[IRC_BIT_ACTIVE]    = active;
        ctrl_view[IRC_BIT_BFMT]      = bfmt_reg;
        ctrl_view[IRC_RATE_LSB +: IRC_RATE_W] = rate_reg;
    end

    // read data valid the cycle after the strobe; unmapped reads return zero
    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            case (reg_addr)
                IRC_CTRL_SET_OFS: reg_rdata <= ctrl_view;
                IRC_CTRL_CLR_OFS: reg_rdata <= ctrl_view;
                IRC_STAT_OFS:     reg_rdata <= {16'h0000, desc_cnt, pkt_cnt};
                default:          reg_rdata <= 32'h0000_0000;
            endcase
        end
    end

    assign desc_fetch_req       = (state_reg == IRC_FETCH);
    assign multi_channel_select = multi_reg;
    assign split_payload_mode   = split_reg;
    assign context_active       = active;

endmodule // irc_context_ctrl

// File: core/irc_pkg.sv
// package: register layout, reset values and state types of the receive context control block
package irc_pkg;

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [7:0]  IRC_CTRL_SET_OFS   = 8'h00; // write 1 to set, read gives control
    localparam logic [7:0]  IRC_CTRL_CLR_OFS   = 8'h04; // write 1 to clear
    localparam logic [7:0]  IRC_STAT_OFS       = 8'h08; // packet and descriptor counters
    localparam logic [31:0] IRC_CTRL_RESET     = 32'h0000_0000;

    // ****************************************************************
    // bit positions
    // ****************************************************************
    localparam int IRC_BIT_FILL      = 31;
    localparam int IRC_BIT_HEADER    = 30;
    localparam int IRC_BIT_CYCMATCH  = 29;
    localparam int IRC_BIT_MULTI     = 28;
    localparam int IRC_BIT_SPLIT     = 27;
    localparam int IRC_BIT_RUN       = 15;
    localparam int IRC_BIT_WAKE      = 12;
    localparam int IRC_BIT_DEAD      = 11;
    localparam int IRC_BIT_ACTIVE    = 10;
    localparam int IRC_BIT_BFMT      = 9;
    localparam int IRC_RATE_LSB      = 0;
    localparam int IRC_RATE_W        = 3;

    // ****************************************************************
    // rate codes and engine states
    // ****************************************************************
    localparam logic [2:0] IRC_RATE_S100 = 3'h0;
    localparam logic [2:0] IRC_RATE_S200 = 3'h1;
    localparam logic [2:0] IRC_RATE_S400 = 3'h2;
    localparam logic [7:0] IRC_CNT_RESET = 8'h00;

    typedef enum logic [1:0] {
        IRC_IDLE,
        IRC_FETCH,
        IRC_RECEIVE,
        IRC_HALT
    } irc_state_t;

endpackage

// File: core/irc_event_cnt.sv
// 8-bit wrapping event counter with synchronous clear
`timescale 1ns/100ps
module irc_event_cnt (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       clear,
    input  wire logic       event_pulse,
    output logic [7:0]      count
);
    import irc_pkg::*;

    // clear wins: a counter restarted by software starts from zero
    always_ff @(posedge clk) begin
        if (rst || clear) begin
            count <= IRC_CNT_RESET;
        end else if (event_pulse) begin
            count <= count + 8'h01;
        end
    end
endmodule // irc_event_cnt

// File: core/irc_portion_split.sv
// splits each payload word stream into leading and trailing portions
`timescale 1ns/100ps
module irc_portion_split (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        enable,
    input  wire logic [15:0] lead_len,
    input  wire logic        word_valid,
    input  wire logic        word_last,
    output logic             to_leading,
    output logic             to_trailing
);
    import irc_pkg::*;

    logic [15:0] pos_reg;

    // word position inside the current packet, restarts after the last word
    always_ff @(posedge clk) begin
        if (rst) begin
            pos_reg <= 16'h0000;
        end else if (word_valid) begin
            pos_reg <= word_last ? 16'h0000 : pos_reg + 16'h0001;
        end
    end

    // steering is combinational so each word goes where its position says
    always_comb begin
        to_leading  = word_valid && (!enable || pos_reg < lead_len);
        to_trailing = word_valid && enable && (pos_reg >= lead_len);
    end
endmodule // irc_portion_split

// File: tb/irc_far_side.sv
// far-side model: descriptor fetch responder for the receive context
`timescale 1ns/100ps
module irc_far_side (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic slow,
    input  wire logic desc_fetch_req,
    output logic      desc_fetch_done
);
    // ****************************************************************
    // fetch answer
    // ****************************************************************
    logic [2:0] wait_cnt;

    // one-cycle done pulse after one or four cycles; the pulse itself
    // restarts the count so a lingering request is answered again one or four cycles after each pulse
    always_ff @(posedge clk) begin
        if (rst || !desc_fetch_req || desc_fetch_done) begin
            wait_cnt        <= 3'h0;
            desc_fetch_done <= 1'b0;
        end else begin
            wait_cnt        <= wait_cnt + 3'h1;
            desc_fetch_done <= (wait_cnt == (slow ? 3'h3 : 3'h0));
        end
    end
endmodule // irc_far_side

// File: tb/irc_context_checker.sv
// checker: port-level assertions for the receive context control block
`timescale 1ns/100ps
module irc_context_checker (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        sw_rst,
    input wire logic [7:0]  reg_addr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic        desc_fetch_req,
    input wire logic        desc_fetch_done,
    input wire logic        pkt_start,
    input wire logic        pkt_b_format,
    input wire logic [2:0]  pkt_rate,
    input wire logic        word_valid,
    input wire logic        leading_portion_series,
    input wire logic        trailing_portion_series,
    input wire logic        multi_channel_select,
    input wire logic        split_payload_mode,
    input wire logic        context_active
);
    import irc_pkg::*;
    // ****************************************************************
    // helper: last rate and format taken while active
    // ****************************************************************
    logic [2:0] seen_rate;
    logic       seen_b;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // packets arriving while stopped must not disturb the status view
    always_ff @(posedge clk) begin
        if (rst || sw_rst) begin
            seen_rate <= 3'h0;
            seen_b    <= 1'b0;
        end else if (pkt_start && context_active) begin
            seen_rate <= pkt_rate;
            seen_b    <= pkt_b_format;
        end
    end

    rsvd_zero_a:
        assert property (reg_rd && reg_addr != IRC_STAT_OFS |=> (reg_rdata & 32'h07ff_6100) == 0)
        else $error("reserved bits read nonzero");
    rate_report_a:
        assert property (reg_rd && reg_addr == IRC_CTRL_SET_OFS && !pkt_start && !sw_rst
            |=> reg_rdata[2:0] == seen_rate && reg_rdata[9] == seen_b)
        else $error("rate or format field wrong");
    split_frozen_a:
        assert property (context_active && !sw_rst |=> $stable(split_payload_mode))
        else $error("split mode changed while active");
    split_clears_a:
        assert property ($rose(split_payload_mode) |-> !multi_channel_select)
        else $error("multichannel left set by split mode");
    reset_zero_a:
        assert property ($past(rst || sw_rst) |-> !multi_channel_select && !split_payload_mode
            && !context_active && !desc_fetch_req) else $error("state not zero after reset");
    fetch_active_a:
        assert property (desc_fetch_req |-> context_active) else $error("fetch while inactive");
    active_rise_a:
        assert property ($rose(context_active) |-> desc_fetch_req) else $error("active without fetch");
    fetch_done_a:
        assert property (desc_fetch_req && desc_fetch_done |=> !desc_fetch_req)
        else $error("fetch request stuck after done");
    portion_route_a:
        assert property (word_valid |-> ((context_active && !desc_fetch_req)
            ? ((leading_portion_series != trailing_portion_series)
               && (split_payload_mode || leading_portion_series))
            : (!leading_portion_series && !trailing_portion_series)))
        else $error("word routed wrongly");
endmodule // irc_context_checker

// File: tb/tb_iso_receive_context_control.sv
// testbench: register and engine scenarios for the receive context control block
`timescale 1ns/100ps
module tb_iso_receive_context_control;
    import irc_pkg::*;
    logic        clk = 1'b0, rst = 1'b1, sw_rst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, slow = 1'b0;
    logic        desc_last = 1'b0, fatal_error = 1'b0, pkt_start = 1'b0, pkt_b_format = 1'b0;
    logic        word_valid = 1'b0, word_last = 1'b0;
    logic        route_split = 1'b1; // expected steering: split mode on or off
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic [2:0]  pkt_rate = 3'h0;
    logic [15:0] lead_len = 16'h0002;
    logic [31:0] reg_rdata;
    logic        desc_fetch_req, desc_fetch_done, leading_portion_series, trailing_portion_series;
    logic        multi_channel_select, split_payload_mode, context_active;
    int          errors = 0, total_checks = 0;

    irc_context_ctrl uut (
        .clk, .rst, .sw_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .desc_fetch_req, .desc_fetch_done, .desc_last, .fatal_error, .pkt_start,
        .pkt_b_format, .pkt_rate, .lead_len, .word_valid, .word_last,
        .leading_portion_series, .trailing_portion_series, .multi_channel_select,
        .split_payload_mode, .context_active
    );
    irc_far_side far_side (.clk, .rst, .slow, .desc_fetch_req, .desc_fetch_done);

    initial forever #20 clk = ~clk;

    // ****************************************************************
    // bus and packet tasks
    // ****************************************************************
    // one step past the edge, so the edge's updates have landed
    task automatic tick;
        @(posedge clk);
        #1;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    // a spare edge after each strobe keeps one assignment per signal per step
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        reg_addr <= a; reg_wdata <= v; reg_wr <= 1'b1;
        tick;
        reg_wr <= 1'b0;
        tick;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        reg_addr <= a; reg_rd <= 1'b1;
        tick;
        reg_rd <= 1'b0;
        v = reg_rdata;
        tick;
    endtask
    task automatic wait_recv;
        int n;
        n = 0;
        while (!(context_active === 1'b1 && desc_fetch_req === 1'b0) && n < 40) begin
            tick;
            n++;
        end
        if (n >= 40) chk("receive state reached", 32'h1, 32'h0);
    endtask
    // four-word packet; with a lead of two, words 2 and 3 go to the trailing series
    task automatic pkt(input logic [2:0] r, input logic b, input logic last);
        pkt_start <= 1'b1; pkt_rate <= r; pkt_b_format <= b; desc_last <= last;
        tick;
        pkt_start <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            word_valid <= 1'b1; word_last <= (i == 3);
            #1;
            chk("routing", {30'h0, i < 2 || !route_split, route_split && i >= 2},
                {30'h0, leading_portion_series, trailing_portion_series});
            tick;
        end
        word_valid <= 1'b0; word_last <= 1'b0;
    endtask
    task automatic complete_run;
        if (errors == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    initial begin
        logic [31:0] d;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        tick;
        rd(IRC_CTRL_SET_OFS, d); chk("ctrl after reset", 32'h0, d);
        rd(8'h0c, d); chk("unmapped read", 32'h0, d);
        wr(IRC_CTRL_SET_OFS, 32'hffff_7fff);
        rd(IRC_CTRL_SET_OFS, d); chk("split over multi and fill", 32'h6800_1000, d);
        chk("multi pin", 32'h0, {31'h0, multi_channel_select});
        wr(IRC_CTRL_CLR_OFS, 32'h0800_0000);
        wr(IRC_CTRL_SET_OFS, 32'h1000_0000);
        rd(IRC_CTRL_CLR_OFS, d); chk("split writable when idle", 32'h7000_1000, d);
        wr(IRC_CTRL_CLR_OFS, 32'hffff_ffff);
        // multichannel stays off in this lone context for the whole run
        wr(IRC_CTRL_SET_OFS, 32'h0800_0000);
        wr(IRC_CTRL_SET_OFS, 32'h0000_8000);
        wait_recv;
        wr(IRC_CTRL_CLR_OFS, 32'h0800_0000);
        rd(IRC_CTRL_SET_OFS, d); chk("split frozen while running", 32'h0800_8400, d);
        chk("split pin", 32'h1, {31'h0, split_payload_mode});
        // every rate code, format flag toggled, prompt and slow fetches
        for (int i = 0; i < 3; i++) begin
            slow <= i[0];
            wait_recv;
            pkt(i[2:0], i[0], 1'b0);
            rd(IRC_CTRL_SET_OFS, d);
            chk("rate and format", 32'h0800_8400 | {22'h0, i[0], 6'h0, i[2:0]}, d);
        end
        wait_recv;
        wr(IRC_CTRL_SET_OFS, 32'h0000_1000);
        rd(IRC_CTRL_SET_OFS, d); chk("wake set", 32'h0800_9402, d);
        pkt(3'h1, 1'b1, 1'b1);
        wait_recv;
        rd(IRC_CTRL_SET_OFS, d); chk("wake cleared by fetch", 32'h0800_8601, d);
        pkt(3'h0, 1'b0, 1'b1);
        tick;
        chk("halted inactive", 32'h0, {31'h0, context_active});
        rd(IRC_CTRL_SET_OFS, d); chk("halted view", 32'h0800_8000, d);
        wr(IRC_CTRL_SET_OFS, 32'h0000_1000);
        wait_recv;
        rd(IRC_CTRL_SET_OFS, d); chk("resumed by wake", 32'h0800_8400, d);
        fatal_error <= 1'b1;
        tick;
        fatal_error <= 1'b0;
        rd(IRC_CTRL_SET_OFS, d); chk("dead, run kept", 32'h0800_8800, d);
        // six descriptor fetches and five packets since run was set
        rd(IRC_STAT_OFS, d); chk("fetch and packet counts", 32'h0000_0605, d);
        wr(IRC_CTRL_CLR_OFS, 32'h0000_8000);
        rd(IRC_CTRL_SET_OFS, d); chk("dead cleared with run", 32'h0800_0000, d);
        rd(IRC_STAT_OFS, d); chk("counts cleared with run", 32'h0, d);
        wr(IRC_CTRL_SET_OFS, 32'h4000_9000);
        sw_rst <= 1'b1;
        tick;
        sw_rst <= 1'b0;
        rd(IRC_CTRL_SET_OFS, d); chk("ctrl after soft reset", 32'h0, d);
        chk("inactive after soft reset", 32'h0, {31'h0, context_active});
        // split off: every word of the packet goes to the leading series
        route_split = 1'b0;
        wr(IRC_CTRL_SET_OFS, 32'h0000_8000);
        wait_recv;
        pkt(IRC_RATE_S400, 1'b1, 1'b0);
        rd(IRC_CTRL_SET_OFS, d); chk("split off status", 32'h0000_8602, d);
        complete_run;
    end

    // hang guard, far beyond the hundred or so cycles the scenarios take
    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        complete_run;
    end
endmodule // tb_iso_receive_context_control

bind irc_context_ctrl irc_context_checker checker_i (
    .clk, .rst, .sw_rst, .reg_addr, .reg_rd, .reg_rdata, .desc_fetch_req, .desc_fetch_done,
    .pkt_start, .pkt_b_format, .pkt_rate, .word_valid, .leading_portion_series,
    .trailing_portion_series, .multi_channel_select, .split_payload_mode, .context_active
);
